// file: core/ncl_top.sv
// Function
// [RL1] codes 11h,12h,21h,22h start update-all, refresh-all, byte write, byte read
// [RL2] host sets auto refresh disable before any memory command
// [RL3] host waits for busy flag low before writing a new code
// [RL4] host writes only the four permitted command codes
// [RL5] write-failure flag sets when a memory write fails
// [RL6] command register is write only and reads back as zero
// [RL7] while locked, writes to the command register are ignored
// [RL8] byte index register gives the location for byte commands
// [RL9] byte value register receives read data and supplies write data
// [RL10] unlock only when written 32-bit key equals stored key mirror
// [RL11] busy rises on accepted command, falls when transfer completes
`timescale 1ns/1ps
`default_nettype none
module ncl_top
  import ncl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] stored_key,
  input  wire logic        nvm_fault,
  output var  logic        nvm_busy_flag,
  output var  logic        nvm_write_fail_flag
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic        wr_stb;
  logic [7:0]  wr_idx;
  logic [7:0]  wr_byte;
  logic        rd_stb;
  logic [7:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic        wr_hit;
  logic [31:0] unlock_key_q;
  logic [7:0]  key_lock_q;
  logic [7:0]  nvm_byte_index_q;
  logic [7:0]  nvm_byte_value_q;
  logic        auto_refresh_disable_q;
  logic        start_q;
  logic [1:0]  op_q;
  logic        eng_busy;
  logic        eng_done;
  logic        eng_fail;
  logic [7:0]  eng_byte;
  logic        fault_s1_q;
  logic        fault_s2_q;
  logic        unlocked;
  logic        code_ok;
  logic [1:0]  code_op;

  // ****************************************************************
  // bus slave
  // ****************************************************************
  ncl_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_idx        (wr_idx),
    .wr_byte       (wr_byte),
    .rd_stb        (rd_stb),
    .rd_idx        (rd_idx),
    .rd_byte       (rd_byte),
    .rd_hit        (rd_hit),
    .wr_hit        (wr_hit)
  );

  // write hit is tied high, so no write index is refused; only the read index is range checked
  always_comb
  begin
    wr_hit = 1'b1;
    rd_hit = (rd_idx >= NCL_IDX_UNLOCK_KEY0) && (rd_idx <= NCL_IDX_KEY_LOCK);
    rd_byte = 8'h00;
    case (rd_idx)
      NCL_IDX_BYTE_INDEX: rd_byte = nvm_byte_index_q;
      NCL_IDX_BYTE_VALUE: rd_byte = nvm_byte_value_q;
      NCL_IDX_COMMAND:    rd_byte = 8'h00; // [RL6]
      NCL_IDX_CONTROL:    rd_byte = {7'h00, auto_refresh_disable_q};
      NCL_IDX_STATUS:     rd_byte = {6'h00, nvm_write_fail_flag, nvm_busy_flag};
      NCL_IDX_KEY_LOCK:   rd_byte = key_lock_q;
      default:            rd_byte = 8'h00;
    endcase
  end

  // ****************************************************************
  // key comparison
  // ****************************************************************
  assign unlocked = (key_lock_q != NCL_KEY_LOCK_ON) || (unlock_key_q == stored_key); // [RL10]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unlock_key_q <= 32'h0000_0000;
      key_lock_q   <= 8'h00;
    end
    else if (wr_stb)
    begin
      case (wr_idx)
        NCL_IDX_UNLOCK_KEY0: unlock_key_q[7:0]   <= wr_byte;
        NCL_IDX_UNLOCK_KEY1: unlock_key_q[15:8]  <= wr_byte;
        NCL_IDX_UNLOCK_KEY2: unlock_key_q[23:16] <= wr_byte;
        NCL_IDX_UNLOCK_KEY3: unlock_key_q[31:24] <= wr_byte;
        NCL_IDX_KEY_LOCK:    if (unlocked) key_lock_q <= wr_byte;
        default:             ;
      endcase
    end
  end

  // ****************************************************************
  // byte index, byte value, control
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nvm_byte_index_q <= NCL_BYTE_INDEX_RST;
    else if (wr_stb && wr_idx == NCL_IDX_BYTE_INDEX && unlocked)
      nvm_byte_index_q <= wr_byte; // [RL8]
  end

  // read result wins over a bus write landing in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nvm_byte_value_q <= NCL_BYTE_VALUE_RST;
    else if (eng_done && op_q == 2'(NCL_OP_READ))
      nvm_byte_value_q <= eng_byte; // [RL9]
    else if (wr_stb && wr_idx == NCL_IDX_BYTE_VALUE && unlocked)
      nvm_byte_value_q <= wr_byte; // [RL9]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      auto_refresh_disable_q <= 1'b0;
    else if (wr_stb && wr_idx == NCL_IDX_CONTROL && unlocked)
      auto_refresh_disable_q <= wr_byte[NCL_CTRL_ARD_BIT];
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  // codes outside the four are dropped; busy writes are dropped too
  always_comb
  begin
    code_ok = 1'b1;
    code_op = 2'(NCL_OP_UPDATE);
    case (wr_byte)
      NCL_CMD_UPDATE_ALL:  code_op = 2'(NCL_OP_UPDATE);
      NCL_CMD_REFRESH_ALL: code_op = 2'(NCL_OP_REFRESH);
      NCL_CMD_WRITE_BYTE:  code_op = 2'(NCL_OP_WRITE);
      NCL_CMD_READ_BYTE:   code_op = 2'(NCL_OP_READ);
      default:             code_ok = 1'b0; // [RL4]
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_q <= 1'b0;
      op_q    <= 2'(NCL_OP_UPDATE);
    end
    else
    begin
      start_q <= 1'b0;
      if (wr_stb && wr_idx == NCL_IDX_COMMAND && unlocked && code_ok // [RL7]
          && !nvm_busy_flag && !start_q) // [RL3]
      begin
        start_q <= 1'b1; // [RL1]
        op_q    <= code_op;
      end
    end
  end

  ncl_mem_engine u_engine (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .start        (start_q),
    .op           (op_q),
    .byte_index   (nvm_byte_index_q),
    .byte_in      (nvm_byte_value_q),
    .fault_inject (fault_s2_q),
    .busy_q       (eng_busy),
    .done_q       (eng_done),
    .fail_q       (eng_fail),
    .byte_out_q   (eng_byte)
  );

  // ****************************************************************
  // status outputs
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_s1_q <= 1'b0;
      fault_s2_q <= 1'b0;
    end
    else
    begin
      fault_s1_q <= nvm_fault;
      fault_s2_q <= fault_s1_q;
    end
  end

  // busy covers the cycle after start too, so a second command cannot slip in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nvm_busy_flag       <= 1'b0;
      nvm_write_fail_flag <= 1'b0;
    end
    else
    begin
      nvm_busy_flag       <= start_q || eng_busy; // [RL11]
      nvm_write_fail_flag <= eng_fail; // [RL5]
    end
  end

endmodule // ncl_top
`default_nettype wire

// file: core/ncl_pkg.sv
package ncl_pkg;

  // ****************************************************************
  // register map (printed offsets not multiples of four: index * 4)
  // ****************************************************************
  localparam logic [7:0]  NCL_IDX_UNLOCK_KEY0  = 8'h39;
  localparam logic [7:0]  NCL_IDX_UNLOCK_KEY1  = 8'h3a;
  localparam logic [7:0]  NCL_IDX_UNLOCK_KEY2  = 8'h3b;
  localparam logic [7:0]  NCL_IDX_UNLOCK_KEY3  = 8'h3c;
  localparam logic [7:0]  NCL_IDX_BYTE_INDEX   = 8'h3d;
  localparam logic [7:0]  NCL_IDX_BYTE_VALUE   = 8'h3e;
  localparam logic [7:0]  NCL_IDX_COMMAND      = 8'h3f;
  localparam logic [7:0]  NCL_IDX_CONTROL      = 8'h40;
  localparam logic [7:0]  NCL_IDX_STATUS       = 8'h41;
  localparam logic [7:0]  NCL_IDX_KEY_LOCK     = 8'h42;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int          NCL_CTRL_ARD_BIT     = 0;
  localparam int          NCL_STAT_BUSY_BIT    = 0;
  localparam int          NCL_STAT_FAIL_BIT    = 1;
  localparam logic [7:0]  NCL_BYTE_INDEX_RST   = 8'hc0;
  localparam logic [7:0]  NCL_BYTE_VALUE_RST   = 8'h00;
  localparam logic [7:0]  NCL_KEY_LOCK_ON      = 8'hff;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0]  NCL_CMD_UPDATE_ALL   = 8'h11;
  localparam logic [7:0]  NCL_CMD_REFRESH_ALL  = 8'h12;
  localparam logic [7:0]  NCL_CMD_WRITE_BYTE   = 8'h21;
  localparam logic [7:0]  NCL_CMD_READ_BYTE    = 8'h22;

  // ****************************************************************
  // memory geometry and timing
  // ****************************************************************
  localparam int          NCL_CFG_BYTES        = 16;
  localparam int          NCL_MEM_BYTES        = 256;
  localparam int          NCL_CLK_MHZ          = 40;
  localparam int          NCL_BYTE_TIME_NS     = 100;
  localparam int          NCL_BYTE_CYCLES      = (NCL_BYTE_TIME_NS * NCL_CLK_MHZ + 999) / 1000;

  // axi responses
  localparam logic [1:0]  NCL_RESP_OKAY        = 2'b00;
  localparam logic [1:0]  NCL_RESP_SLVERR      = 2'b10;

  typedef enum logic [1:0] {NCL_OP_UPDATE, NCL_OP_REFRESH, NCL_OP_WRITE, NCL_OP_READ} ncl_op_e;

endpackage

// file: core/ncl_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module ncl_axil_slave
  import ncl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic        wr_stb,
  output var  logic [7:0]  wr_idx,
  output var  logic [7:0]  wr_byte,
  output var  logic        rd_stb,
  output var  logic [7:0]  rd_idx,
  input  wire logic [7:0]  rd_byte,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);

  // ****************************************************************
  // write channel: address and data taken in either order
  // ****************************************************************
  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  aw_idx_q;
  logic [7:0]  w_byte_q;
  logic        w_lane_q;
  logic        do_wr;

  assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_idx_q      <= 8'h00;
      w_byte_q      <= 8'h00;
      w_lane_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_full_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end
      else if (do_wr)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      else if (do_wr)
        w_full_q <= 1'b0;
    end
  end

  // strobe only when lane 0 is enabled; upper lanes hold nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_stb       <= 1'b0;
      wr_idx       <= 8'h00;
      wr_byte      <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= NCL_RESP_OKAY;
    end
    else
    begin
      wr_stb <= do_wr && w_lane_q && wr_hit;
      if (do_wr)
      begin
        wr_idx       <= aw_idx_q;
        wr_byte      <= w_byte_q;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? NCL_RESP_OKAY : NCL_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // read channel: data and rvalid registered on the same edge that accepts the address
  // ****************************************************************
  logic rd_wait_q;

  assign rd_idx = s_axi_araddr[9:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      rd_wait_q     <= 1'b0;
      rd_stb        <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= NCL_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !rd_wait_q && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      rd_stb        <= s_axi_arvalid && s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_wait_q    <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? NCL_RESP_OKAY : NCL_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        rd_wait_q    <= 1'b0;
      end
    end
  end

endmodule // ncl_axil_slave
`default_nettype wire

// file: core/ncl_mem_engine.sv
`timescale 1ns/1ps
`default_nettype none
module ncl_mem_engine
  import ncl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic [1:0]  op,
  input  wire logic [7:0]  byte_index,
  input  wire logic [7:0]  byte_in,
  input  wire logic        fault_inject,
  output var  logic        busy_q,
  output var  logic        done_q,
  output var  logic        fail_q,
  output var  logic [7:0]  byte_out_q
);

  // ****************************************************************
  // nonvolatile array and its ram mirror of the config bytes
  // ****************************************************************
  logic [7:0]  mem_q    [NCL_MEM_BYTES];
  logic [7:0]  mirror_q [NCL_CFG_BYTES];
  logic [7:0]  step_q;
  logic [7:0]  cnt_q;
  logic [7:0]  last_q;
  logic [1:0]  op_q;
  logic [7:0]  idx_q;
  logic        tick;

  assign tick = busy_q && (cnt_q == 8'(NCL_BYTE_CYCLES - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      cnt_q  <= 8'h00;
      step_q <= 8'h00;
      last_q <= 8'h00;
      op_q   <= 2'b00;
      idx_q  <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q  <= 8'h00;
        step_q <= 8'h00;
        op_q   <= op;
        idx_q  <= byte_index;
        last_q <= (op == 2'(NCL_OP_UPDATE) || op == 2'(NCL_OP_REFRESH))
                  ? 8'(NCL_CFG_BYTES - 1) : 8'h00;
        if (op == 2'(NCL_OP_UPDATE) || op == 2'(NCL_OP_WRITE))
          fail_q <= 1'b0;
      end
      else if (busy_q)
      begin
        cnt_q <= tick ? 8'h00 : cnt_q + 8'h01;
        if (tick && fault_inject && (op_q == 2'(NCL_OP_UPDATE) || op_q == 2'(NCL_OP_WRITE)))
          fail_q <= 1'b1;
        if (tick)
        begin
          step_q <= step_q + 8'h01;
          if (step_q == last_q)
          begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end

  // array contents have no reset: a nonvolatile store keeps its value
  always_ff @(posedge aclk)
  begin
    if (tick && !fault_inject)
    begin
      case (op_q)
        2'(NCL_OP_UPDATE):  mem_q[8'hc0 + step_q] <= mirror_q[step_q[3:0]];
        2'(NCL_OP_WRITE):   mem_q[idx_q] <= byte_in;
        default:            ;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (tick && op_q == 2'(NCL_OP_REFRESH))
      mirror_q[step_q[3:0]] <= mem_q[8'hc0 + step_q];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      byte_out_q <= NCL_BYTE_VALUE_RST;
    else if (tick && op_q == 2'(NCL_OP_READ))
      byte_out_q <= mem_q[idx_q];
  end

endmodule // ncl_mem_engine
`default_nettype wire

// file: verif/ncl_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module ncl_top_props
  import ncl_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        nvm_busy_flag,
  input wire logic        nvm_write_fail_flag
);
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == NCL_RESP_OKAY)
    else $error("write response not okay");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == NCL_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_busy_cause: assert property ($rose(nvm_busy_flag) |-> $past(s_axi_bvalid, 2))
    else $error("busy without command write");
  a_busy_ends: assert property ($rose(nvm_busy_flag) |-> ##[1:80] !nvm_busy_flag)
    else $error("busy never clears");
  a_fail_set: assert property ($rose(nvm_write_fail_flag) |-> $past(nvm_busy_flag))
    else $error("fail flag outside transfer");
  a_fail_clear: assert property ($fell(nvm_write_fail_flag) |-> ##[0:2] nvm_busy_flag)
    else $error("fail flag cleared without start");
  c_busy_done: cover property ($fell(nvm_busy_flag));
  c_fail: cover property ($rose(nvm_write_fail_flag));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == NCL_RESP_SLVERR);
endmodule // ncl_top_props
bind ncl_top ncl_top_props ncl_top_props_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .nvm_busy_flag(nvm_busy_flag),
  .nvm_write_fail_flag(nvm_write_fail_flag));
`default_nettype wire

// file: verif/ncl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ncl_host_model
(
  input  wire logic        aclk,
  output var  logic [31:0] awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [31:0] araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // ****************************************************************
  // bus master; only one transfer at a time
  // ****************************************************************
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  // ready values read right after the edge are the sampled ones
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // ncl_host_model
`default_nettype wire

// file: verif/ncl_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ncl_top_tb_top
  import ncl_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, nvm_fault = 1'b0;
  logic [31:0] stored_key = 32'h1234abcd;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy, fail;
  int mismatches = 0;
  int checks_done = 0;
  int b, u;
  logic [7:0]  bad_codes [3] = '{8'h00, 8'h33, 8'hff};
  logic [31:0] try_keys  [2] = '{32'h1234abcc, 32'h1234abcd};

  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  ncl_top ncl_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .stored_key(stored_key), .nvm_fault(nvm_fault),
    .nvm_busy_flag(busy), .nvm_write_fail_flag(fail));
  ncl_host_model ncl_host_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] a4(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    ncl_host_model_i.rd(a4(idx), d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    ncl_host_model_i.wr(a4(idx), {24'h0, v});
  endtask
  // busy cycles of one command; 0 when refused
  task automatic run_cmd(input logic [7:0] c, output int n);
    int k;
    wr(NCL_IDX_COMMAND, c);
    n = 0;
    for (k = 0; k < 8 && busy !== 1'b1; k++) @(posedge aclk);
    while (busy === 1'b1 && n < 500)
    begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    #(25ns * 30000);
    mismatches++;
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(NCL_IDX_BYTE_INDEX, 32'hc0, NCL_RESP_OKAY);
    rchk(NCL_IDX_BYTE_VALUE, 32'h00, NCL_RESP_OKAY);
    rchk(NCL_IDX_COMMAND, 32'h0, NCL_RESP_OKAY);
    rchk(NCL_IDX_STATUS, 32'h0, NCL_RESP_OKAY);
    rchk(8'h80, 32'h0, NCL_RESP_SLVERR);
    $display("test reset done");
    wr(NCL_IDX_CONTROL, 8'h01);
    rchk(NCL_IDX_CONTROL, 32'h1, NCL_RESP_OKAY);
    // two locations so a stuck index cannot pass
    wr(NCL_IDX_BYTE_INDEX, 8'h10);
    wr(NCL_IDX_BYTE_VALUE, 8'h5a);
    run_cmd(NCL_CMD_WRITE_BYTE, b);
    chk(b > 0 && b <= 3 * NCL_BYTE_CYCLES, 1);
    rchk(NCL_IDX_COMMAND, 32'h0, NCL_RESP_OKAY);
    wr(NCL_IDX_BYTE_INDEX, 8'h20);
    wr(NCL_IDX_BYTE_VALUE, 8'ha5);
    run_cmd(NCL_CMD_WRITE_BYTE, b);
    wr(NCL_IDX_BYTE_VALUE, 8'h00);
    wr(NCL_IDX_BYTE_INDEX, 8'h10);
    run_cmd(NCL_CMD_READ_BYTE, b);
    rchk(NCL_IDX_BYTE_VALUE, 32'h5a, NCL_RESP_OKAY);
    wr(NCL_IDX_BYTE_INDEX, 8'h20);
    run_cmd(NCL_CMD_READ_BYTE, b);
    rchk(NCL_IDX_BYTE_VALUE, 32'ha5, NCL_RESP_OKAY);
    rchk(NCL_IDX_STATUS, 32'h0, NCL_RESP_OKAY);
    $display("test byte access done");
    run_cmd(NCL_CMD_UPDATE_ALL, u);
    chk(u >= (NCL_CFG_BYTES - 1) * NCL_BYTE_CYCLES && u < 80, 1);
    run_cmd(NCL_CMD_REFRESH_ALL, u);
    chk(u >= (NCL_CFG_BYTES - 1) * NCL_BYTE_CYCLES && u < 80, 1);
    $display("test update refresh done");
    nvm_fault <= 1'b1;
    repeat (4) @(posedge aclk);
    run_cmd(NCL_CMD_WRITE_BYTE, b);
    chk(fail, 1'b1);
    rchk(NCL_IDX_STATUS, 32'h2, NCL_RESP_OKAY);
    nvm_fault <= 1'b0;
    repeat (4) @(posedge aclk);
    run_cmd(NCL_CMD_WRITE_BYTE, b);
    chk(fail, 1'b0);
    $display("test write failure done");
    foreach (bad_codes[i])
    begin
      run_cmd(bad_codes[i], b);
      chk(b, 0);
    end
    $display("test bad codes done");
    wr(NCL_IDX_KEY_LOCK, NCL_KEY_LOCK_ON);
    run_cmd(NCL_CMD_WRITE_BYTE, b);
    chk(b, 0);
    // one bit off in the lowest byte
    foreach (try_keys[j])
    begin
      for (int k = 0; k < 4; k++)
        wr(NCL_IDX_UNLOCK_KEY0 + 8'(k), try_keys[j][8*k +: 8]);
      run_cmd(NCL_CMD_WRITE_BYTE, b);
      chk(b > 0, j == 1);
    end
    $display("test protection done");
    end_sim();
  end
endmodule // ncl_top_tb_top
`default_nettype wire
